/* src/lsor_pkg.sv */
// Purpose: Shared constants, types and helpers for the status and parameter readout link
// Assumes: Both ends run on one clock; bytes move one per cycle on the link
// Notes: Checksums are the classic carry-wrapped sum, inverted, over data bytes only

package lsor_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Identifiers and command bytes
  localparam logic [7:0] ID_MASTER_REQ = 8'h3c;
  localparam logic [7:0] ID_SLAVE_RESP = 8'h7d;
  localparam logic [7:0] APP_CMD = 8'h80;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic CMD_MARK = 1'h1;
  localparam logic [6:0] CMD_FULL_STATUS = 7'h01;
  localparam logic [6:0] CMD_PARAM_READ = 7'h02;
  localparam logic FS_FIXED_ONE = 1'h1;
  localparam logic [1:0] FS_PAD_ZERO = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame lengths (data bytes, checksum excluded except in PREP_BYTES, PREP7_LEN and PREP8_LEN)
  localparam int RESP_BYTES = 8;
  localparam int PREP_BYTES = 9;
  localparam logic [3:0] RESP_LEN = 4'h8;
  localparam logic [3:0] STATUS_LEN = 4'h2;
  localparam logic [3:0] PREP7_LEN = 4'h3;
  localparam logic [3:0] PREP8_LEN = 4'h9;
  localparam int PREP8_FILL_FIRST = 3;
  localparam int PREP8_FILL_LAST = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter memory layout
  localparam int OTP_DEPTH = 10;
  localparam int OTP_AW = 4;
  localparam int OTP_DIRECT_LAST = 4;
  localparam int OTP_MAIN_LO = 5;
  localparam int OTP_MAIN_HI = 6;
  localparam int OTP_TAIL = 7;
  localparam int OTP_ALT_LO = 8;
  localparam int OTP_ALT_HI = 9;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag set vector positions
  localparam int FS_TW = 0;
  localparam int FS_TSD = 1;
  localparam int FS_UV = 2;
  localparam int FS_SL = 3;
  localparam int FS_VDD = 4;
  localparam int FS_W = 5;

  localparam int HOST_TIMEOUT = 32;

  typedef enum {PEND_NONE, PEND_FULL, PEND_PARAM} lsor_pend_t;
  typedef enum logic [1:0] {HCMD_STATUS, HCMD_PARAM7, HCMD_PARAM8, HCMD_FULL7} lsor_hcmd_t;

  function automatic logic [7:0] csum_add(input logic [7:0] acc, input logic [7:0] b);
    logic [8:0] s;
    s = {1'h0, acc} + {1'h0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic [7:0] prot_id(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

endpackage

/* src/lsor_link_if.sv */
// Purpose: Byte level link between bus master and slave node
// Assumes: Same clock on both ends; strobes are one-cycle pulses
// Notes: m_* driven by the master, s_* by the slave

`timescale 1ns/1ps
`default_nettype none

interface lsor_link_if;
  logic m_hdr;
  logic m_dat;
  logic m_end;
  logic [7:0] m_byte;
  logic s_dat;
  logic s_last;
  logic [7:0] s_byte;

  modport device (input m_hdr, m_dat, m_end, m_byte, output s_dat, s_last, s_byte);
  modport host (output m_hdr, m_dat, m_end, m_byte, input s_dat, s_last, s_byte);
endinterface

`default_nettype wire

/* src/lsor_device.sv */
// Purpose: Slave node end: serves status, full-status and parameter memory readouts
// Assumes: Link strobes come from logic on I_CLK, so no synchroniser is used
// Notes: Only the second full-status response is produced by this block

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Full response: address, positions high first, secure low
// - Bytes 7 and 8 pack stall parameters
// - Readout answers only after a matching preparing frame
// - Memory readout uses the indirect response identifier
// - Master sends type 7 then reading frame
// - Type 7 layout: direct id, command, address
// - Master sends type 8 then reading frame
// - Type 8 layout: request id, app command, fill
// - Readout bytes 1-5 and 8 from memory
// - Bytes 6 and 7 chosen by select bit
// - Quick status read clears five fault flags
// - Open-coil-only defect clears on quick read
// - Short-coil defect clears only on full read
// - Quick status: two bytes on direct id
// - Quick status byte layout with address, flags
module lsor_device #(
  parameter int OTP_DEPTH = lsor_pkg::OTP_DEPTH
) (
  input wire logic I_CLK, // System clock
  input wire logic I_SRST, // Synchronous reset, active high
  lsor_link_if.device link, // Bus side
  input wire logic [6:0] I_NODE_ADDR, // Own node address
  input wire logic [5:0] I_STATUS_ID, // Direct id of the quick status read
  input wire logic [5:0] I_PREP_ID, // Direct id of type 7 preparing frames
  input wire logic [15:0] I_ACTUAL_POSITION, // Actual position
  input wire logic [15:0] I_TARGET_POSITION, // Target position
  input wire logic [10:0] I_SECURE_POSITION, // Secure position
  input wire logic I_SECURE_POSITION_SELECT, // Memory readout source select
  input wire logic [2:0] I_FULL_STEP_STALL_ENABLE, // Stall enable field
  input wire logic I_FULL_DUTY_FLAG, // Full duty flag
  input wire logic I_ABSOLUTE_STALL_FLAG, // Absolute stall flag
  input wire logic [2:0] I_STALL_SAMPLE_COUNT, // Stall sample count
  input wire logic I_FULL_DUTY_STALL_ENABLE, // Full duty stall enable
  input wire logic I_PWM_JITTER_ENABLE, // PWM jitter enable
  input wire logic I_MOTION_SWITCH_STATE, // Motion switch state
  input wire logic [1:0] I_TEMP_INFO, // Temperature info
  input wire logic [lsor_pkg::FS_W-1:0] I_FLAG_SET, // Fault flag set pulses
  input wire logic I_OPEN_COIL_SET, // Open coil detected pulse
  input wire logic I_SHORT_COIL_SET, // Short coil detected pulse
  input wire logic I_OTP_WE, // Parameter memory write
  input wire logic [lsor_pkg::OTP_AW-1:0] I_OTP_ADDR, // Parameter memory address
  input wire logic [7:0] I_OTP_DATA, // Parameter memory data
  output logic [7:0] O_STATUS, // Fault flags as sent in quick status
  output logic O_FULL_READ_DONE, // Pulse: full-status response started
  output logic O_FRAME_ERR // Pulse: preparing frame dropped on checksum
);

  generate
    if (OTP_DEPTH < lsor_pkg::OTP_DEPTH || OTP_DEPTH > (1 << lsor_pkg::OTP_AW))
    begin : g_bad_depth
      $error("OTP_DEPTH out of range");
    end
  endgenerate

  typedef enum {ST_IDLE, ST_RX, ST_TX} lsor_dstate_t;

  lsor_dstate_t state;
  lsor_pkg::lsor_pend_t pend;
  logic [7:0] otp_mem [OTP_DEPTH];
  logic [7:0] rx_buf [lsor_pkg::PREP_BYTES];
  logic [7:0] tx_buf [lsor_pkg::RESP_BYTES];
  logic [7:0] resp [lsor_pkg::RESP_BYTES];
  logic [3:0] resp_len;
  logic [3:0] rx_cnt;
  logic [3:0] tx_idx;
  logic [3:0] tx_len;
  logic [7:0] acc;
  logic [7:0] acc_prev;
  logic [7:0] rx_last;
  logic rx_type8;
  logic [lsor_pkg::FS_W-1:0] flag;
  logic open_coil;
  logic short_coil;
  logic hdr_prep7;
  logic hdr_prep8;
  logic hdr_read;
  logic hdr_stat;
  logic full_now;
  logic [7:0] status_byte;
  logic prep_done;
  logic cs_ok;
  logic fields_ok;
  logic [6:0] rx_cmd;

  ////////////////////////////////////////////////////////////////////////////////
  // Header decode
  assign hdr_prep7 = link.m_hdr && (link.m_byte == lsor_pkg::prot_id(I_PREP_ID));
  assign hdr_prep8 = link.m_hdr && (link.m_byte == lsor_pkg::ID_MASTER_REQ);
  assign hdr_read = link.m_hdr && (link.m_byte == lsor_pkg::ID_SLAVE_RESP)
                    && (pend != lsor_pkg::PEND_NONE);
  assign hdr_stat = link.m_hdr && (link.m_byte == lsor_pkg::prot_id(I_STATUS_ID));
  assign full_now = hdr_read && (pend == lsor_pkg::PEND_FULL);

  assign status_byte = {flag[lsor_pkg::FS_VDD], flag[lsor_pkg::FS_SL], open_coil | short_coil,
                        flag[lsor_pkg::FS_UV], flag[lsor_pkg::FS_TSD], flag[lsor_pkg::FS_TW],
                        I_TEMP_INFO};

  ////////////////////////////////////////////////////////////////////////////////
  // Response assembly, snapshotted at the header
  always_comb
  begin
    for (int i = 0; i < lsor_pkg::RESP_BYTES; i++)
    begin
      resp[i] = 8'h00;
    end
    resp_len = lsor_pkg::RESP_LEN;
    if (hdr_stat)
    begin
      resp[0] = {I_MOTION_SWITCH_STATE, I_NODE_ADDR};
      resp[1] = status_byte;
      resp_len = lsor_pkg::STATUS_LEN;
    end
    else if (pend == lsor_pkg::PEND_PARAM)
    begin
      for (int i = 0; i <= lsor_pkg::OTP_DIRECT_LAST; i++)
      begin
        resp[i] = otp_mem[i];
      end
      resp[lsor_pkg::OTP_MAIN_LO] = I_SECURE_POSITION_SELECT ? otp_mem[lsor_pkg::OTP_ALT_LO]
                                                             : otp_mem[lsor_pkg::OTP_MAIN_LO];
      resp[lsor_pkg::OTP_MAIN_HI] = I_SECURE_POSITION_SELECT ? otp_mem[lsor_pkg::OTP_ALT_HI]
                                                             : otp_mem[lsor_pkg::OTP_MAIN_HI];
      resp[lsor_pkg::OTP_TAIL] = otp_mem[lsor_pkg::OTP_TAIL];
    end
    else
    begin
      resp[0] = {lsor_pkg::CMD_MARK, I_NODE_ADDR};
      resp[1] = I_ACTUAL_POSITION[15:8];
      resp[2] = I_ACTUAL_POSITION[7:0];
      resp[3] = I_TARGET_POSITION[15:8];
      resp[4] = I_TARGET_POSITION[7:0];
      resp[5] = I_SECURE_POSITION[7:0];
      resp[6] = {I_FULL_STEP_STALL_ENABLE, lsor_pkg::FS_FIXED_ONE, I_FULL_DUTY_FLAG,
                 I_SECURE_POSITION[10:8]};
      resp[7] = {I_ABSOLUTE_STALL_FLAG, lsor_pkg::FS_PAD_ZERO, I_STALL_SAMPLE_COUNT,
                 I_FULL_DUTY_STALL_ENABLE, I_PWM_JITTER_ENABLE};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame engine; a header always restarts it because the master owns the bus
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      state <= ST_IDLE;
      tx_idx <= 4'h0;
      tx_len <= 4'h0;
      acc <= 8'h00;
      acc_prev <= 8'h00;
      rx_cnt <= 4'h0;
      rx_last <= 8'h00;
      rx_type8 <= 1'h0;
      link.s_dat <= 1'h0;
      link.s_last <= 1'h0;
      link.s_byte <= 8'h00;
    end
    else
    begin
      link.s_dat <= 1'h0;
      link.s_last <= 1'h0;
      if (link.m_hdr)
      begin
        acc <= 8'h00;
        rx_cnt <= 4'h0;
        tx_idx <= 4'h0;
        rx_type8 <= hdr_prep8;
        tx_buf <= resp;
        tx_len <= resp_len;
        if (hdr_prep7 || hdr_prep8)
        begin
          state <= ST_RX;
        end
        else if (hdr_read || hdr_stat)
        begin
          state <= ST_TX;
        end
        else
        begin
          state <= ST_IDLE;
        end
      end
      else
      begin
        case (state)
          ST_RX:
          begin
            if (link.m_dat && rx_cnt < lsor_pkg::PREP8_LEN)
            begin
              acc_prev <= acc;
              acc <= lsor_pkg::csum_add(acc, link.m_byte);
              rx_last <= link.m_byte;
              rx_cnt <= rx_cnt + 4'h1;
            end
            if (link.m_end)
            begin
              state <= ST_IDLE;
            end
          end
          ST_TX:
          begin
            link.s_dat <= 1'h1;
            if (tx_idx == tx_len)
            begin
              link.s_byte <= ~acc;
              link.s_last <= 1'h1;
              state <= ST_IDLE;
            end
            else
            begin
              link.s_byte <= tx_buf[tx_idx[2:0]];
              acc <= lsor_pkg::csum_add(acc, tx_buf[tx_idx[2:0]]);
              tx_idx <= tx_idx + 4'h1;
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (state == ST_RX && link.m_dat && !link.m_hdr && rx_cnt < lsor_pkg::PREP8_LEN)
    begin
      rx_buf[rx_cnt] <= link.m_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Preparing frame check and pending readout
  assign prep_done = (state == ST_RX) && link.m_end && !link.m_hdr;
  assign cs_ok = (rx_cnt != 4'h0) && (~acc_prev == rx_last);
  assign rx_cmd = rx_type8 ? rx_buf[1][6:0] : rx_buf[0][6:0];

  always_comb
  begin
    if (rx_type8)
    begin
      fields_ok = (rx_cnt == lsor_pkg::PREP8_LEN) && (rx_buf[0] == lsor_pkg::APP_CMD)
                  && (rx_buf[1][7] == lsor_pkg::CMD_MARK)
                  && (rx_buf[2] == {lsor_pkg::CMD_MARK, I_NODE_ADDR});
      for (int i = lsor_pkg::PREP8_FILL_FIRST; i <= lsor_pkg::PREP8_FILL_LAST; i++)
      begin
        fields_ok = fields_ok && (rx_buf[i] == lsor_pkg::FILL_BYTE);
      end
    end
    else
    begin
      fields_ok = (rx_cnt == lsor_pkg::PREP7_LEN) && (rx_buf[0][7] == lsor_pkg::CMD_MARK)
                  && (rx_buf[1] == {lsor_pkg::CMD_MARK, I_NODE_ADDR});
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      pend <= lsor_pkg::PEND_NONE;
    end
    else if (prep_done && cs_ok)
    begin
      // Another node's frame cancels ours so we never answer for it
      if (fields_ok && rx_cmd == lsor_pkg::CMD_PARAM_READ)
      begin
        pend <= lsor_pkg::PEND_PARAM;
      end
      else if (fields_ok && rx_cmd == lsor_pkg::CMD_FULL_STATUS)
      begin
        pend <= lsor_pkg::PEND_FULL;
      end
      else
      begin
        pend <= lsor_pkg::PEND_NONE;
      end
    end
    else if (hdr_read)
    begin
      pend <= lsor_pkg::PEND_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fault flags; a set pulse in the clearing cycle survives
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      flag <= '0;
      open_coil <= 1'h0;
      short_coil <= 1'h0;
    end
    else
    begin
      flag <= I_FLAG_SET | (flag & {lsor_pkg::FS_W{~hdr_stat}});
      open_coil <= I_OPEN_COIL_SET | (open_coil & ~hdr_stat & ~full_now);
      short_coil <= I_SHORT_COIL_SET | (short_coil & ~full_now);
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_OTP_WE && int'(I_OTP_ADDR) < OTP_DEPTH)
    begin
      otp_mem[I_OTP_ADDR] <= I_OTP_DATA;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_STATUS <= 8'h00;
      O_FULL_READ_DONE <= 1'h0;
      O_FRAME_ERR <= 1'h0;
    end
    else
    begin
      O_STATUS <= status_byte;
      O_FULL_READ_DONE <= full_now;
      O_FRAME_ERR <= prep_done && !cs_ok;
    end
  end

endmodule // lsor_device

`default_nettype wire

/* src/lsor_host.sv */
// Purpose: Bus master end: issues preparing and reading frames, collects answers
// Assumes: One command at a time; I_CMD_GO ignored while busy
// Notes: A missing answer ends the command after TIMEOUT_CYC cycles with O_OK low

`timescale 1ns/1ps
`default_nettype none

module lsor_host #(
  parameter int TIMEOUT_CYC = lsor_pkg::HOST_TIMEOUT
) (
  input wire logic I_CLK, // System clock
  input wire logic I_SRST, // Synchronous reset, active high
  lsor_link_if.host link, // Bus side
  input wire logic I_CMD_GO, // Pulse: start command
  input wire logic [1:0] I_CMD, // Command kind
  input wire logic [6:0] I_NODE_ADDR, // Target node address
  input wire logic [5:0] I_STATUS_ID, // Quick status direct id
  input wire logic [5:0] I_PREP_ID, // Type 7 direct id, bit 5 clear
  output logic O_BUSY, // Command in progress
  output logic O_DONE, // Pulse: command finished
  output logic O_OK, // Answer complete with good checksum
  output logic [63:0] O_RX_DATA, // Answer bytes, latest in [63:56]
  output logic [3:0] O_RX_COUNT // Answer data bytes received
);

  generate
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 255)
    begin : g_bad_timeout
      $error("TIMEOUT_CYC out of range");
    end
  endgenerate

  typedef enum {H_IDLE, H_PREP, H_READ, H_WAIT} lsor_hstate_t;

  lsor_hstate_t state;
  logic [7:0] tx_buf [lsor_pkg::PREP_BYTES];
  logic [7:0] next_tx [lsor_pkg::PREP_BYTES];
  logic [3:0] next_len;
  logic [3:0] tx_len;
  logic [3:0] idx;
  logic [7:0] acc;
  logic [7:0] read_id;
  logic [7:0] prep_hdr;
  logic [3:0] exp_len;
  logic [7:0] tmo;
  logic [6:0] cmd_code;
  lsor_pkg::lsor_hcmd_t cmd;

  assign cmd = lsor_pkg::lsor_hcmd_t'(I_CMD);
  assign cmd_code = (cmd == lsor_pkg::HCMD_FULL7) ? lsor_pkg::CMD_FULL_STATUS
                                                  : lsor_pkg::CMD_PARAM_READ;

  ////////////////////////////////////////////////////////////////////////////////
  // Preparing frame contents
  always_comb
  begin
    for (int i = 0; i < lsor_pkg::PREP_BYTES; i++)
    begin
      next_tx[i] = lsor_pkg::FILL_BYTE;
    end
    if (cmd == lsor_pkg::HCMD_PARAM8)
    begin
      next_tx[0] = lsor_pkg::APP_CMD;
      next_tx[1] = {lsor_pkg::CMD_MARK, cmd_code};
      next_tx[2] = {lsor_pkg::CMD_MARK, I_NODE_ADDR};
      next_len = lsor_pkg::PREP8_LEN - 4'h1;
    end
    else
    begin
      next_tx[0] = {lsor_pkg::CMD_MARK, cmd_code};
      next_tx[1] = {lsor_pkg::CMD_MARK, I_NODE_ADDR};
      next_len = lsor_pkg::PREP7_LEN - 4'h1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      state <= H_IDLE;
      idx <= 4'h0;
      acc <= 8'h00;
      tx_len <= 4'h0;
      read_id <= 8'h00;
      prep_hdr <= 8'h00;
      exp_len <= 4'h0;
      tmo <= 8'h00;
      link.m_hdr <= 1'h0;
      link.m_dat <= 1'h0;
      link.m_end <= 1'h0;
      link.m_byte <= 8'h00;
      O_BUSY <= 1'h0;
      O_DONE <= 1'h0;
      O_OK <= 1'h0;
      O_RX_DATA <= 64'h0;
      O_RX_COUNT <= 4'h0;
    end
    else
    begin
      link.m_hdr <= 1'h0;
      link.m_dat <= 1'h0;
      link.m_end <= 1'h0;
      O_DONE <= 1'h0;
      case (state)
        H_IDLE:
        begin
          if (I_CMD_GO)
          begin
            O_BUSY <= 1'h1;
            O_OK <= 1'h0;
            O_RX_DATA <= 64'h0;
            O_RX_COUNT <= 4'h0;
            idx <= 4'h0;
            acc <= 8'h00;
            tx_buf <= next_tx;
            tx_len <= next_len;
            prep_hdr <= (cmd == lsor_pkg::HCMD_PARAM8) ? lsor_pkg::ID_MASTER_REQ
                                                       : lsor_pkg::prot_id(I_PREP_ID);
            if (cmd == lsor_pkg::HCMD_STATUS)
            begin
              read_id <= lsor_pkg::prot_id(I_STATUS_ID);
              exp_len <= lsor_pkg::STATUS_LEN;
              state <= H_READ;
            end
            else
            begin
              read_id <= lsor_pkg::ID_SLAVE_RESP;
              exp_len <= lsor_pkg::RESP_LEN;
              state <= H_PREP;
            end
          end
        end
        H_PREP:
        begin
          idx <= idx + 4'h1;
          if (idx == 4'h0)
          begin
            link.m_hdr <= 1'h1;
            link.m_byte <= prep_hdr;
          end
          else if (idx <= tx_len)
          begin
            link.m_dat <= 1'h1;
            link.m_byte <= tx_buf[idx - 4'h1];
            acc <= lsor_pkg::csum_add(acc, tx_buf[idx - 4'h1]);
          end
          else if (idx == tx_len + 4'h1)
          begin
            link.m_dat <= 1'h1;
            link.m_byte <= ~acc;
          end
          else
          begin
            link.m_end <= 1'h1;
            state <= H_READ;
          end
        end
        H_READ:
        begin
          // Reading frame follows the preparing frame, never precedes it
          link.m_hdr <= 1'h1;
          link.m_byte <= read_id;
          acc <= 8'h00;
          tmo <= 8'h00;
          state <= H_WAIT;
        end
        H_WAIT:
        begin
          tmo <= tmo + 8'h01;
          if (link.s_dat && link.s_last)
          begin
            O_OK <= (O_RX_COUNT == exp_len) && (link.s_byte == ~acc);
            O_DONE <= 1'h1;
            O_BUSY <= 1'h0;
            state <= H_IDLE;
          end
          else if (link.s_dat)
          begin
            acc <= lsor_pkg::csum_add(acc, link.s_byte);
            O_RX_DATA <= {link.s_byte, O_RX_DATA[63:8]};
            O_RX_COUNT <= O_RX_COUNT + 4'h1;
            tmo <= 8'h00;
          end
          else if (int'(tmo) >= TIMEOUT_CYC)
          begin
            O_DONE <= 1'h1;
            O_BUSY <= 1'h0;
            state <= H_IDLE;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule // lsor_host

`default_nettype wire

/* bench/lsor_link_sva.sv */
// Purpose: Protocol checks on the readout link
// Assumes: One clock, synchronous reset
// Notes: Sees only the link signals
`timescale 1ns/1ps
`default_nettype none

module lsor_link_sva (
  input wire logic I_CLK, // Clock
  input wire logic I_SRST, // Reset
  input wire logic m_hdr, // Header strobe
  input wire logic m_dat, // Data strobe
  input wire logic m_end, // Frame end
  input wire logic [7:0] m_byte, // Master byte
  input wire logic s_dat, // Answer strobe
  input wire logic s_last, // Checksum strobe
  input wire logic [7:0] s_byte // Answer byte
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  logic [7:0] acc;
  logic [8:0] sum;
  assign sum = {1'h0, acc} + {1'h0, s_byte};
  // A header restarts the sum, since it aborts any answer in flight
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST || s_last || m_hdr)
      acc <= 8'h00;
    else if (s_dat)
      acc <= sum[7:0] + {7'h00, sum[8]};
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_quick;
    s_dat && !s_last ##1 s_dat && !s_last ##1 s_dat && s_last;
  endsequence
  sequence s_long;
    (s_dat && !s_last) [*8] ##1 s_dat && s_last;
  endsequence
  property p_last_in_byte;
    s_last |-> s_dat;
  endproperty
  property p_quick_len;
    m_hdr && m_byte != 8'h7d ##2 s_dat |-> s_quick ##1 !s_dat;
  endproperty
  property p_read_len;
    m_hdr && m_byte == 8'h7d ##2 s_dat |-> s_long ##1 !s_dat;
  endproperty
  property p_csum;
    s_last |-> s_byte == ~acc;
  endproperty
  property p_prep_silent;
    m_hdr && m_byte == 8'h3c |-> ##2 !s_dat;
  endproperty
  property p_cause;
    $rose(s_dat) |-> $past(m_hdr, 2);
  endproperty
  property p_quiet;
    m_dat || m_end |-> !s_dat;
  endproperty
  property p_gap;
    s_last |=> !s_dat;
  endproperty
  a_last_in_byte: assert property (p_last_in_byte) else $error("checksum without strobe");
  a_quick_len: assert property (p_quick_len) else $error("quick answer length");
  a_read_len: assert property (p_read_len) else $error("readout length");
  a_csum: assert property (p_csum) else $error("answer checksum wrong");
  a_prep_silent: assert property (p_prep_silent) else $error("answer to preparing frame");
  a_cause: assert property (p_cause) else $error("answer without header");
  a_quiet: assert property (p_quiet) else $error("answer during master bytes");
  a_gap: assert property (p_gap) else $error("answer runs past checksum");
endmodule // lsor_link_sva

`default_nettype wire

/* bench/test_lin_status_otp_readout.sv */
// Purpose: Self-checking bench for both link ends
// Assumes: Host and device share one clock
// Notes: Random fields come from an LFSR with a fixed seed
`timescale 1ns/1ps
`default_nettype none

module test_lin_status_otp_readout;
  logic clk = 0;
  logic srst = 1;
  logic go = 0;
  logic [1:0] cmd = 0;
  logic [6:0] haddr = 7'h15;
  logic [5:0] sid = 6'h11;
  int nfrd = 0, nerr = 0;
  logic [63:0] v = 0;
  logic [4:0] fset = 0;
  logic oc = 0;
  logic sc = 0;
  logic we = 0;
  logic [3:0] wa = 0;
  logic [7:0] wd = 0;
  logic [7:0] mem [10];
  logic [31:0] rnd = 32'h82895fc7;
  int fails = 0;
  int total_checks = 0;
  logic busy, done, ok, ferr, frd;
  logic [63:0] rx;
  logic [3:0] cnt;
  logic [7:0] stat;
  always #50 clk = ~clk;
  lsor_link_if lsor_link_if_i ();
  lsor_device lsor_device_i (.I_CLK(clk), .I_SRST(srst), .link(lsor_link_if_i),
    .I_NODE_ADDR(7'h15), .I_STATUS_ID(sid), .I_PREP_ID(6'h05),
    .I_ACTUAL_POSITION(v[15:0]), .I_TARGET_POSITION(v[31:16]),
    .I_SECURE_POSITION(v[42:32]), .I_SECURE_POSITION_SELECT(v[43]),
    .I_FULL_STEP_STALL_ENABLE(v[46:44]), .I_FULL_DUTY_FLAG(v[47]),
    .I_ABSOLUTE_STALL_FLAG(v[48]), .I_STALL_SAMPLE_COUNT(v[51:49]),
    .I_FULL_DUTY_STALL_ENABLE(v[52]), .I_PWM_JITTER_ENABLE(v[53]),
    .I_MOTION_SWITCH_STATE(v[54]), .I_TEMP_INFO(v[56:55]), .I_FLAG_SET(fset),
    .I_OPEN_COIL_SET(oc), .I_SHORT_COIL_SET(sc), .I_OTP_WE(we), .I_OTP_ADDR(wa),
    .I_OTP_DATA(wd), .O_STATUS(stat), .O_FULL_READ_DONE(frd), .O_FRAME_ERR(ferr));
  lsor_host #(.TIMEOUT_CYC(16)) lsor_host_i (.I_CLK(clk), .I_SRST(srst),
    .link(lsor_link_if_i), .I_CMD_GO(go), .I_CMD(cmd), .I_NODE_ADDR(haddr),
    .I_STATUS_ID(sid), .I_PREP_ID(6'h05), .O_BUSY(busy), .O_DONE(done), .O_OK(ok),
    .O_RX_DATA(rx), .O_RX_COUNT(cnt));
  lsor_link_sva lsor_link_sva_i (.I_CLK(clk), .I_SRST(srst),
    .m_hdr(lsor_link_if_i.m_hdr), .m_dat(lsor_link_if_i.m_dat),
    .m_end(lsor_link_if_i.m_end), .m_byte(lsor_link_if_i.m_byte),
    .s_dat(lsor_link_if_i.s_dat), .s_last(lsor_link_if_i.s_last),
    .s_byte(lsor_link_if_i.s_byte));
  // Pulses last a whole cycle, so the falling edge always sees them
  always @(negedge clk)
  begin
    nfrd += frd;
    nerr += ferr;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [63:0] full_exp();
    return {v[48], 2'h0, v[51:49], v[52], v[53], v[46:44], 1'h1, v[47], v[42:40],
      v[39:32], v[23:16], v[31:24], v[7:0], v[15:8], 8'h95};
  endfunction
  function automatic logic [63:0] param_exp();
    return {mem[7], v[43] ? mem[9] : mem[6], v[43] ? mem[8] : mem[5],
      mem[4], mem[3], mem[2], mem[1], mem[0]};
  endfunction
  function automatic logic [15:0] quick_exp(input logic [5:0] f);
    return {f, v[56:55], v[54], 7'h15};
  endfunction
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ok(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [1:0] c);
    int n;
    n = 0;
    @(negedge clk);
    cmd = c;
    go = 1;
    @(negedge clk);
    go = 0;
    while (done !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
      fails++;
    chk_ok(busy, 1'h0);
  endtask
  task automatic pulse(input logic [4:0] f, input logic o, input logic s);
    @(negedge clk);
    fset = f;
    oc = o;
    sc = s;
    @(negedge clk);
    fset = 0;
    oc = 0;
    sc = 0;
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #3000000;
    fails++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(negedge clk);
    srst = 0;
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      @(negedge clk);
      we = 1;
      wa = i[3:0];
      wd = rnd[7:0];
      mem[i] = rnd[7:0];
    end
    @(negedge clk);
    we = 0;
    // Both preparing formats, each with both readout sources
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      v[31:0] = rnd;
      rnd = lfsr(rnd);
      v[63:32] = rnd;
      v[43] = k[1];
      run(2'h3);
      chk_data(rx, full_exp());
      run(k[0] ? 2'h2 : 2'h1);
      chk_data(rx, param_exp());
      chk_data(cnt, 4'h8);
      chk_ok(ok, 1'h1);
      $display("test readout %0d done", k);
    end
    pulse(5'h1f, 1'h1, 1'h0);
    run(2'h0);
    chk_data(rx[63:48], quick_exp(6'h3f));
    chk_data(cnt, 4'h2);
    run(2'h0);
    chk_data(rx[63:48], quick_exp(6'h00));
    chk_data(stat, {6'h00, v[56:55]});
    rnd = lfsr(rnd);
    pulse(rnd[4:0], 1'h0, 1'h0);
    run(2'h0);
    chk_data(rx[63:48], quick_exp({rnd[4:3], 1'h0, rnd[2:0]}));
    pulse(5'h00, 1'h0, 1'h1);
    run(2'h0);
    run(2'h0);
    chk_data(rx[63:48], quick_exp(6'h08));
    run(2'h3);
    run(2'h0);
    chk_data(rx[63:48], quick_exp(6'h00));
    $display("test status done");
    haddr = 7'h16;
    run(2'h1);
    chk_ok(ok, 1'h0);
    haddr = 7'h15;
    run(2'h2);
    chk_ok(ok, 1'h1);
    $display("test address done");
    chk_data(nfrd, 5);
    chk_data(nerr, 0);
    give_verdict();
  end
endmodule // test_lin_status_otp_readout

`default_nettype wire
